// *** rtl/ssx_pkg.sv ***
package ssx_pkg;
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam logic [5:0] OP_SUB = 6'h02;
  localparam logic [5:0] OP_SWAP = 6'h0e;
  localparam logic [8:0] OP_DIR = 9'h000;
  localparam int DEST_BIT = 5;
  localparam logic [2:0] DIR_PORT_LO = 3'h5;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam int DIR_PORTS = 3;

  typedef enum logic [1:0] {
    SSX_NONE,
    SSX_SUB,
    SSX_SWAP,
    SSX_DIR
  } ssx_op_t;

  typedef struct packed {
    ssx_op_t op;
    logic dest;
    logic [4:0] faddr;
    logic [2:0] port;
  } ssx_dec_t;

  typedef struct packed {
    logic carry;
    logic nibble_borrow_flag;
    logic zero;
  } ssx_flags_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [2:0][7:0] dir;
    logic file_we;
    logic [4:0] file_waddr;
    logic [7:0] file_wdata;
    logic flags_we;
    ssx_flags_t flags;
    logic sync1;
    logic sync2;
  } ssx_state_t;
endpackage : ssx_pkg

// *** rtl/ssx_decode.sv ***
`timescale 1ns/100ps
module ssx_decode (
  input wire logic [11:0] insn,
  output ssx_pkg::ssx_dec_t dec
);
  always_comb begin
    dec.dest = insn[ssx_pkg::DEST_BIT];
    dec.faddr = insn[4:0]; // [RULE6]
    dec.port = insn[2:0];
    dec.op = ssx_pkg::SSX_NONE;
    if (insn[11:6] == ssx_pkg::OP_SUB) begin
      dec.op = ssx_pkg::SSX_SUB;
    end else if (insn[11:6] == ssx_pkg::OP_SWAP) begin
      dec.op = ssx_pkg::SSX_SWAP; // [RULE4]
    end else if (insn[11:3] == ssx_pkg::OP_DIR
                 && insn[2:0] >= ssx_pkg::DIR_PORT_LO) begin
      dec.op = ssx_pkg::SSX_DIR; // [RULE7]
    end
  end
endmodule : ssx_decode

// *** rtl/ssx_exec.sv ***
// Overview of operation
// (RULE1) subtract accumulator from file via two's complement
// (RULE2) dest 0: difference to accumulator only
// (RULE3) dest 1: difference back to file register
// (RULE4) decode 0011 10df ffff as nibble exchange
// (RULE5) exchange result to accumulator or file by dest
// (RULE6) five-bit file address, one destination bit
// (RULE7) decode 0000 0000 0fff, accumulator to direction register; code takes fff 5 to 7 only, lower values change nothing
// (RULE8) carry means no borrow; nibble borrow; zero flag
`timescale 1ns/100ps
module ssx_exec (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [11:0] insn,
  input wire logic insn_valid,
  input wire logic [7:0] file_rdata,
  output logic [4:0] file_raddr,
  output logic file_we,
  output logic [4:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic flags_we,
  output ssx_pkg::ssx_flags_t flags,
  output logic [7:0] acc,
  output logic [2:0][7:0] dir
);
  ssx_pkg::ssx_state_t s;
  ssx_pkg::ssx_state_t next_s;
  ssx_pkg::ssx_dec_t dec;
  logic rst_n;
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic [7:0] result;

  ssx_decode u_dec (
    .insn(insn),
    .dec(dec)
  );

  // file address comes straight from the instruction word so the register
  // file can answer combinationally in the same cycle
  assign file_raddr = dec.faddr;
  assign rst_n = s.sync2;
  assign diff = {1'b0, file_rdata} + {1'b0, ~s.acc} + 9'h001; // [RULE1]
  assign ldiff = {1'b0, file_rdata[3:0]} + {1'b0, ~s.acc[3:0]} + 5'h01;

  always_comb begin
    next_s = s;
    next_s.sync1 = 1'b1;
    next_s.sync2 = s.sync1;
    next_s.file_we = 1'b0;
    next_s.flags_we = 1'b0;
    result = 8'h00;
    if (insn_valid) begin
      case (dec.op)
        ssx_pkg::SSX_SUB: begin
          result = diff[7:0];
          next_s.flags_we = 1'b1;
          next_s.flags.carry = diff[8]; // [RULE8]
          next_s.flags.nibble_borrow_flag = ldiff[4]; // [RULE8]
          next_s.flags.zero = (diff[7:0] == 8'h00); // [RULE8]
        end
        ssx_pkg::SSX_SWAP: begin
          result = {file_rdata[3:0], file_rdata[7:4]}; // [RULE4]
        end
        ssx_pkg::SSX_DIR: begin
          next_s.dir[2'(dec.port - ssx_pkg::DIR_PORT_LO)] = s.acc; // [RULE7]
        end
        default: begin
          result = 8'h00;
        end
      endcase
      if (dec.op == ssx_pkg::SSX_SUB || dec.op == ssx_pkg::SSX_SWAP) begin
        if (dec.dest) begin
          next_s.file_we = 1'b1; // [RULE3] [RULE5]
          next_s.file_waddr = dec.faddr;
          next_s.file_wdata = result;
        end else begin
          next_s.acc = result; // [RULE2] [RULE5]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{acc: ssx_pkg::ACC_RESET,
             dir: {3{ssx_pkg::DIR_RESET}},
             file_waddr: 5'h00, file_wdata: 8'h00,
             flags: 3'h0, default: 1'b0};
    end else if (clk_en) begin
      if (!rst_n) begin
        s <= '{acc: ssx_pkg::ACC_RESET,
               dir: {3{ssx_pkg::DIR_RESET}},
               file_waddr: 5'h00, file_wdata: 8'h00,
               flags: 3'h0, sync1: 1'b1, sync2: s.sync1,
               default: 1'b0};
      end else begin
        s <= next_s;
      end
    end
  end

  assign acc = s.acc;
  assign dir = s.dir;
  assign file_we = s.file_we;
  assign file_waddr = s.file_waddr;
  assign file_wdata = s.file_wdata;
  assign flags_we = s.flags_we;
  assign flags = s.flags;

  a_sub_acc: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_SUB && !dec.dest
    |=> acc == $past(file_rdata) - $past(acc) && !file_we)
    else $error("subtract to accumulator wrong");
  a_sub_file: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_SUB && dec.dest
    |=> file_we && file_wdata == $past(file_rdata) - $past(acc)
        && acc == $past(acc))
    else $error("subtract to file wrong");
  a_sub_carry: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_SUB
    |=> flags_we && flags.carry == ($past(file_rdata) >= $past(acc))
        && flags.zero == ($past(file_rdata) == $past(acc)))
    else $error("subtract flags wrong");
  a_swap_acc: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    clk_en && insn_valid && insn[11:6] == 6'h0e && !insn[5]
    |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap to accumulator wrong");
  a_swap_file: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    clk_en && insn_valid && insn[11:6] == 6'h0e && insn[5]
    |=> file_we && !flags_we
        && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap to file wrong");
  a_dir_load: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    clk_en && insn_valid && insn == 12'h006
    |=> dir[1] == $past(acc) && acc == $past(acc))
    else $error("direction load wrong");
  a_addr_pass: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    clk_en && insn_valid && dec.op != ssx_pkg::SSX_NONE && insn[5]
    && dec.op != ssx_pkg::SSX_DIR |=> file_waddr == $past(insn[4:0]))
    else $error("file address wrong");
  a_sub_twos: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_SUB
    |=> flags.nibble_borrow_flag
        == ($past(file_rdata[3:0]) >= $past(acc[3:0])))
    else $error("nibble borrow wrong");

  // one instruction is taken per enabled edge; the chained checks below use
  // these to catch a strobe or a state change that outlives its cycle
  sequence s_take_sub;
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_SUB;
  endsequence

  sequence s_take_swap;
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_SWAP;
  endsequence

  sequence s_take_dir;
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_DIR;
  endsequence

  sequence s_take_none;
    clk_en && insn_valid && dec.op == ssx_pkg::SSX_NONE;
  endsequence

  sequence s_idle_edge;
    clk_en && !insn_valid;
  endsequence

  sequence s_sub_to_file;
    s_take_sub ##0 dec.dest;
  endsequence

  a_sub_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    s_sub_to_file ##1 s_idle_edge |=> !file_we && !flags_we)
    else $error("write strobe longer than one cycle");

  a_swap_keep: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    s_take_swap ##0 dec.dest |=> $stable(acc))
    else $error("exchange to file changed the accumulator");

  a_swap_flags: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    s_take_swap |=> !flags_we && $stable(flags))
    else $error("exchange touched the flags");

  a_dir_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    s_take_dir |=> !file_we && !flags_we && $stable(acc))
    else $error("direction load disturbed other state");

  a_dir_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    clk_en && insn_valid && insn[11:3] == ssx_pkg::OP_DIR
    && insn[2:0] < ssx_pkg::DIR_PORT_LO
    |=> $stable(dir) && $stable(acc) && !file_we && !flags_we)
    else $error("refused direction number changed state");

  // one check per direction register: only the addressed entry may move
  for (genvar i = 0; i < ssx_pkg::DIR_PORTS; i++) begin : g_dir_chk
    a_dir_each: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
      s_take_dir |=> dir[i] == ($past(insn[2:0])
          == 3'(ssx_pkg::DIR_PORT_LO + i) ? $past(acc) : $past(dir[i])))
      else $error("direction entry wrong");
  end

  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    s_idle_edge |=> !file_we && !flags_we && $stable(acc) && $stable(dir))
    else $error("state moved without an instruction");

  a_unknown_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_none |=> !file_we && !flags_we && $stable(acc) && $stable(dir))
    else $error("unknown opcode changed state");

  // the write strobe is held, not repeated, across a stall; a register file
  // that ignores the enable would write the same word more than once
  a_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(acc) && $stable(dir) && $stable(flags)
    && $stable(file_we) && $stable(flags_we) && $stable(file_wdata))
    else $error("state moved while the enable was low");

  // kept outside the disable so that the values under reset are seen too
  a_reset_vals: assert property (@(posedge clk)
    !reset_n |=> acc == ssx_pkg::ACC_RESET && dir == {3{ssx_pkg::DIR_RESET}}
    && !file_we && !flags_we && flags == 3'h0)
    else $error("reset values wrong");

  a_sync_hold: assert property (@(posedge clk)
    reset_n && !rst_n |=> acc == ssx_pkg::ACC_RESET && !file_we && !flags_we)
    else $error("instruction taken before reset was released");
endmodule : ssx_exec

// *** tb/ssx_prog_mem.sv ***
`timescale 1ns/100ps
module ssx_prog_mem (
  input wire logic [3:0] pc,
  output logic [11:0] insn
);
  logic [11:0] rom [16];
  // words are written one slot ahead of pc, so a fetch never sees a change
  initial foreach (rom[i]) rom[i] = 12'h000;
  assign insn = rom[pc];
endmodule : ssx_prog_mem

// *** tb/test_subtract_swap_tristate_exec.sv ***
`timescale 1ns/100ps
module test_subtract_swap_tristate_exec;
  logic clk = 0, reset_n = 0, clk_en = 0, insn_valid = 0, tk = 0;
  logic [3:0] pc = 4'h0;
  logic [11:0] insn, w;
  logic [7:0] file_rdata = 8'h00, file_wdata, acc, r, d, wd, a = 8'h00;
  logic [4:0] file_raddr, file_waddr, wa;
  logic file_we, flags_we, we, fwe;
  ssx_pkg::ssx_flags_t flags, fl = '0;
  logic [2:0][7:0] dir, dr = {3{8'hff}};
  logic [49:0] q[$], e, o;
  int num_errors = 0, n_compared = 0, seed = 32'h4b66, k;
  always #25 clk = ~clk;
  ssx_prog_mem pm (.pc(pc), .insn(insn));
  ssx_exec dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .insn(insn), .insn_valid(insn_valid), .file_rdata(file_rdata),
    .file_raddr(file_raddr), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .flags_we(flags_we), .flags(flags),
    .acc(acc), .dir(dir));
  // write address and data only matter while a write is pulsed
  assign o = {acc, file_we, file_we ? {file_waddr, file_wdata} : 13'h0,
    flags_we, flags, dir};
  task chk(input string n, input logic [49:0] x, input logic [49:0] g);
    n_compared++;
    if (x !== g) begin
      $display("BAD %s expected %h seen %h", n, x, g);
      num_errors++;
    end
  endtask : chk
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) tk <= clk_en & insn_valid;
  always @(negedge clk) if (tk) begin
    if (q.size() == 0) begin
      $display("BAD result_queue expected 1 seen 0");
      num_errors++;
    end else begin
      e = q.pop_front();
      chk("acc", e[49:42], o[49:42]);
      chk("file", e[41:28], o[41:28]);
      chk("flags", e[27:24], o[27:24]);
      chk("dir", e[23:0], o[23:0]);
    end
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      // the second pass resets in mid-run, so the model starts over as well
      reset_n <= 1'b0;
      clk_en <= 1'b0;
      insn_valid <= 1'b0;
      a = ssx_pkg::ACC_RESET;
      dr = {3{ssx_pkg::DIR_RESET}};
      fl = '0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      // the enable must run for the reset synchroniser to let go
      clk_en <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 300; i++) begin
        @(posedge clk);
        k = $random(seed);
        r = 8'($random(seed));
        w = k[1:0] == 2'h0 ? {6'h02, k[13:8]} : k[1:0] == 2'h1 ?
          {6'h0e, k[13:8]} : k[1:0] == 2'h2 ? {9'h000, k[10:8]} : k[27:16];
        pm.rom[pc + 4'h1] = w;
        pc <= pc + 4'h1;
        file_rdata <= r;
        clk_en <= k[4] | k[5];
        insn_valid <= k[6] | k[7];
        if ((k[4] | k[5]) && (k[6] | k[7])) begin
          we = 0;
          fwe = 0;
          if (w[11:6] == 6'h02 || w[11:6] == 6'h0e) begin
            d = w[8] ? {r[3:0], r[7:4]} : r - a;
            if (!w[8]) begin
              fwe = 1;
              fl = {r >= a, r[3:0] >= a[3:0], r == a};
            end
            if (w[5]) begin
              we = 1;
              wa = w[4:0];
              wd = d;
            end else a = d;
          end else if (w[11:3] == 9'h000 && w[2:0] >= 3'h5)
            dr[w[2:0] - 3'h5] = a;
          q.push_back({a, we, we ? {wa, wd} : 13'h0, fwe, fl, dr});
        end
      end
      // let the last word be taken, then stop issuing
      @(posedge clk);
      insn_valid <= 1'b0;
      repeat (2) @(posedge clk);
      $display("random pass %0d done", p);
    end
    if (q.size() != 0) num_errors++;
    end_sim();
  end
endmodule : test_subtract_swap_tristate_exec
